// ### tbt_pkg.sv
// constants, register map and control layout of the type b timer pair
package tbt_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;

  localparam logic [7:0] OFF_EVEN_CTRL   = 8'h00;
  localparam logic [7:0] OFF_EVEN_COUNT  = 8'h04;
  localparam logic [7:0] OFF_EVEN_PERIOD = 8'h08;
  localparam logic [7:0] OFF_ODD_CTRL    = 8'h10;
  localparam logic [7:0] OFF_ODD_COUNT   = 8'h14;
  localparam logic [7:0] OFF_ODD_PERIOD  = 8'h18;

  localparam int unsigned BIT_ON        = 15;
  localparam int unsigned BIT_IDLE_STOP = 13;
  localparam int unsigned BIT_GATE      = 7;
  localparam int unsigned PS_MSB        = 6;
  localparam int unsigned PS_LSB        = 4;
  localparam int unsigned BIT_PAIR      = 3;
  localparam int unsigned BIT_CS        = 1;

  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;

  localparam logic [2:0] PS_DIV_1   = 3'h0;
  localparam logic [2:0] PS_DIV_2   = 3'h1;
  localparam logic [2:0] PS_DIV_4   = 3'h2;
  localparam logic [2:0] PS_DIV_8   = 3'h3;
  localparam logic [2:0] PS_DIV_16  = 3'h4;
  localparam logic [2:0] PS_DIV_32  = 3'h5;
  localparam logic [2:0] PS_DIV_64  = 3'h6;
  localparam logic [2:0] PS_DIV_256 = 3'h7;

  typedef struct packed {
    logic       on;
    logic       idle_stop;
    logic       gate_accumulate_en;
    logic [2:0] clock_prescale_sel;
    logic       pair_wide_mode;
    logic       clock_source_sel;
  } tbt_ctrl_t;

endpackage

// ### tbt_sync.sv
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module tbt_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync_out;

  always_comb begin
    next_stage1   = rst_n ? async_in : '0;
    next_sync_out = rst_n ? stage1 : '0;
  end

  // stage1 feeds only the second flop
  always_ff @(posedge clk) begin
    stage1   <= next_stage1;
    sync_out <= next_sync_out;
  end

endmodule

// ### tbt_prescaler.sv
// input clock prescaler with eight selectable ratios
`timescale 1ns/10ps
module tbt_prescaler #(
  parameter int unsigned CW = 8
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [2:0] sel,
  output logic            tick_out
);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [CW-1:0] limit;

  function automatic logic [CW-1:0] ps_limit(input logic [2:0] s);
    logic [7:0] l;
    l = 8'h00;
    unique case (s)
      tbt_pkg::PS_DIV_1:   l = 8'h00;
      tbt_pkg::PS_DIV_2:   l = 8'h01;
      tbt_pkg::PS_DIV_4:   l = 8'h03;
      tbt_pkg::PS_DIV_8:   l = 8'h07;
      tbt_pkg::PS_DIV_16:  l = 8'h0f;
      tbt_pkg::PS_DIV_32:  l = 8'h1f;
      tbt_pkg::PS_DIV_64:  l = 8'h3f;
      tbt_pkg::PS_DIV_256: l = 8'hff;
    endcase
    return CW'(l);
  endfunction

  assign limit    = ps_limit(sel);
  assign tick_out = tick_in && (cnt == limit);

  always_comb begin
    next_cnt = cnt;
    if (!rst_n || clear) begin
      next_cnt = '0;
    end else if (tick_in) begin
      next_cnt = (cnt == limit) ? '0 : cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    cnt <= next_cnt;
  end

endmodule

// ### tbt_timer_pair.sv
// even/odd type b timer pair with control, count and period registers
//
// Contract
// - the on bit at position 15 enables the timer and clearing it stops it.
// - with idle stop set the timer halts in idle mode, else it keeps running unless the odd idle stop bit holds the pair.
// - with external clock selected the gate bit is ignored and reads zero.
// - with internal clock selected the gate bit turns gated accumulation on.
// - prescale codes 0 to 7 divide by 1,2,4,8,16,32,64 and 256.
// - the prescale field sits in bits 6 to 4 of the control register.
// - only the even timer implements the pairing bit.
// - in paired mode the odd timer's on, gate, prescale, source bits do nothing.
`timescale 1ns/10ps
module tbt_timer_pair (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  input  wire logic        idle_mode,
  input  wire logic        ext_clk_even,
  input  wire logic        ext_clk_odd,
  output logic             match_even,
  output logic             match_odd,
  output logic             gate_done_even,
  output logic             gate_done_odd
);

  tbt_pkg::tbt_ctrl_t ctrl_e;
  tbt_pkg::tbt_ctrl_t ctrl_o;
  tbt_pkg::tbt_ctrl_t next_ctrl_e;
  tbt_pkg::tbt_ctrl_t next_ctrl_o;
  logic [15:0]        cnt_e;
  logic [15:0]        cnt_o;
  logic [15:0]        per_e;
  logic [15:0]        per_o;
  logic [15:0]        next_cnt_e;
  logic [15:0]        next_cnt_o;
  logic [15:0]        next_per_e;
  logic [15:0]        next_per_o;
  logic [31:0]        next_rdata;
  logic               next_match_e;
  logic               next_match_o;
  logic               next_gdone_e;
  logic               next_gdone_o;
  logic [1:0]         pin_sync;
  logic [1:0]         pin_prev;
  logic [1:0]         next_pin_prev;
  logic               paired;
  logic               run_e;
  logic               run_o;
  logic               src_e;
  logic               src_o;
  logic               tick_e;
  logic               tick_o;
  logic [31:0]        wide_cnt;
  logic [31:0]        wide_per;

  // unpack a bus word into control fields
  function automatic tbt_pkg::tbt_ctrl_t ctrl_from_word(
    input logic [31:0] w,
    input logic        is_even
  );
    tbt_pkg::tbt_ctrl_t c;
    c.on                 = w[tbt_pkg::BIT_ON];
    c.idle_stop          = w[tbt_pkg::BIT_IDLE_STOP];
    c.gate_accumulate_en = w[tbt_pkg::BIT_GATE];
    c.clock_prescale_sel = w[tbt_pkg::PS_MSB:tbt_pkg::PS_LSB];
    c.pair_wide_mode     = is_even & w[tbt_pkg::BIT_PAIR];
    c.clock_source_sel   = w[tbt_pkg::BIT_CS];
    return c;
  endfunction

  // pack control fields into a read word
  function automatic logic [31:0] word_from_ctrl(
    input tbt_pkg::tbt_ctrl_t c
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[tbt_pkg::BIT_ON]        = c.on;
    w[tbt_pkg::BIT_IDLE_STOP] = c.idle_stop;
    w[tbt_pkg::BIT_GATE]      = c.gate_accumulate_en & ~c.clock_source_sel;
    w[tbt_pkg::PS_MSB:tbt_pkg::PS_LSB] = c.clock_prescale_sel;
    w[tbt_pkg::BIT_PAIR]      = c.pair_wide_mode;
    w[tbt_pkg::BIT_CS]        = c.clock_source_sel;
    return w;
  endfunction

  // count source: bus clock, pin edge, or bus clock gated by pin level
  function automatic logic count_source(
    input tbt_pkg::tbt_ctrl_t c,
    input logic               level,
    input logic               rise
  );
    logic s;
    s = 1'b1;
    if (c.clock_source_sel) begin
      s = rise;
    end else if (c.gate_accumulate_en) begin
      s = level;
    end
    return s;
  endfunction

  // pins are asynchronous to clk
  // a pulse shorter than one clock can be missed entirely
  tbt_sync #(
    .W (2)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({ext_clk_odd, ext_clk_even}),
    .sync_out (pin_sync)
  );

  // prev resets low to match an idle low pin, so no false rise
  always_comb begin
    next_pin_prev = rst_n ? pin_sync : 2'h0;
  end

  always_ff @(posedge clk) begin
    pin_prev <= next_pin_prev;
  end

  // the odd pair bit is never stored, so only even can pair
  // even pairing bit joins the pair
  assign paired = ctrl_e.pair_wide_mode;

  // odd idle stop still holds the pair
  assign run_e = ctrl_e.on
               & ~(idle_mode & ctrl_e.idle_stop)
               & ~(paired & idle_mode & ctrl_o.idle_stop);

  assign run_o = ~paired & ctrl_o.on & ~(idle_mode & ctrl_o.idle_stop);

  assign src_e = count_source(ctrl_e, pin_sync[0],
                              pin_sync[0] & ~pin_prev[0]);
  assign src_o = count_source(ctrl_o, pin_sync[1],
                              pin_sync[1] & ~pin_prev[1]);

  // clearing while stopped makes every start a full prescale span
  // divide before the counter
  tbt_prescaler #(
    .CW (8)
  ) u_ps_even (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (~run_e),
    .tick_in  (run_e & src_e),
    .sel      (ctrl_e.clock_prescale_sel),
    .tick_out (tick_e)
  );

  tbt_prescaler #(
    .CW (8)
  ) u_ps_odd (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (~run_o),
    .tick_in  (run_o & src_o),
    .sel      (ctrl_o.clock_prescale_sel),
    .tick_out (tick_o)
  );

  // odd half on top, so the carry runs from even into odd
  assign wide_cnt = {cnt_o, cnt_e};
  assign wide_per = {per_o, per_e};

  // control and period registers
  always_comb begin
    next_ctrl_e = ctrl_e;
    next_ctrl_o = ctrl_o;
    next_per_e  = per_e;
    next_per_o  = per_o;
    if (!rst_n) begin
      next_ctrl_e = ctrl_from_word(tbt_pkg::CTRL_RESET, 1'b1);
      next_ctrl_o = ctrl_from_word(tbt_pkg::CTRL_RESET, 1'b0);
      next_per_e  = tbt_pkg::PERIOD_RESET;
      next_per_o  = tbt_pkg::PERIOD_RESET;
    end else if (wr_en) begin
      unique case (addr)
        tbt_pkg::OFF_EVEN_CTRL:   next_ctrl_e = ctrl_from_word(wdata, 1'b1);
        tbt_pkg::OFF_ODD_CTRL:    next_ctrl_o = ctrl_from_word(wdata, 1'b0);
        tbt_pkg::OFF_EVEN_PERIOD: next_per_e  = wdata[15:0];
        tbt_pkg::OFF_ODD_PERIOD:  next_per_o  = wdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    ctrl_e <= next_ctrl_e;
    ctrl_o <= next_ctrl_o;
    per_e  <= next_per_e;
    per_o  <= next_per_o;
  end

  // counters; a software write to a count wins over a tick
  // a tick lost to such a write is not made up later
  always_comb begin
    next_cnt_e   = cnt_e;
    next_cnt_o   = cnt_o;
    next_match_e = 1'b0;
    next_match_o = 1'b0;
    if (!rst_n) begin
      next_cnt_e = tbt_pkg::COUNT_RESET;
      next_cnt_o = tbt_pkg::COUNT_RESET;
    end else begin
      if (paired && tick_e) begin
        if (wide_cnt == wide_per) begin
          next_cnt_e   = tbt_pkg::COUNT_RESET;
          next_cnt_o   = tbt_pkg::COUNT_RESET;
          next_match_e = 1'b1;
        end else begin
          {next_cnt_o, next_cnt_e} = wide_cnt + 32'h0000_0001;
        end
      end else if (!paired) begin
        if (tick_e) begin
          next_match_e = (cnt_e == per_e);
          next_cnt_e   = (cnt_e == per_e) ? tbt_pkg::COUNT_RESET
                                          : cnt_e + 16'h0001;
        end
        if (tick_o) begin
          next_match_o = (cnt_o == per_o);
          next_cnt_o   = (cnt_o == per_o) ? tbt_pkg::COUNT_RESET
                                          : cnt_o + 16'h0001;
        end
      end
      if (wr_en && addr == tbt_pkg::OFF_EVEN_COUNT) begin
        next_cnt_e = wdata[15:0];
      end
      if (wr_en && addr == tbt_pkg::OFF_ODD_COUNT) begin
        next_cnt_o = wdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    cnt_e      <= next_cnt_e;
    cnt_o      <= next_cnt_o;
    match_even <= next_match_e;
    match_odd  <= next_match_o;
  end

  // end of a gated window: falling pin while gating is active
  // lets software read the accumulated count once the gate closes
  always_comb begin
    next_gdone_e = 1'b0;
    next_gdone_o = 1'b0;
    if (rst_n) begin
      next_gdone_e = run_e & ctrl_e.gate_accumulate_en
                   & ~ctrl_e.clock_source_sel
                   & pin_prev[0] & ~pin_sync[0];
      next_gdone_o = run_o & ctrl_o.gate_accumulate_en
                   & ~ctrl_o.clock_source_sel
                   & pin_prev[1] & ~pin_sync[1];
    end
  end

  always_ff @(posedge clk) begin
    gate_done_even <= next_gdone_e;
    gate_done_odd  <= next_gdone_o;
  end

  // read data valid only in the cycle after the strobe
  // zero elsewhere, so several slaves can share an or-ed bus
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rst_n && rd_en) begin
      unique case (addr)
        tbt_pkg::OFF_EVEN_CTRL:   next_rdata = word_from_ctrl(ctrl_e);
        tbt_pkg::OFF_ODD_CTRL:    next_rdata = word_from_ctrl(ctrl_o);
        tbt_pkg::OFF_EVEN_COUNT:  next_rdata = {16'h0000, cnt_e};
        tbt_pkg::OFF_ODD_COUNT:   next_rdata = {16'h0000, cnt_o};
        tbt_pkg::OFF_EVEN_PERIOD: next_rdata = {16'h0000, per_e};
        tbt_pkg::OFF_ODD_PERIOD:  next_rdata = {16'h0000, per_o};
        default:                  next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    rdata <= next_rdata;
  end

endmodule

// ### tbt_timer_pair_properties.sv
// checker for register reads and match outputs of the timer pair
`timescale 1ns/10ps
module tbt_timer_pair_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  input wire logic        match_even,
  input wire logic        match_odd,
  input wire logic        gate_done_even
);
  logic on_q;
  logic pair_q;
  logic next_on;
  logic next_pair;
  logic mapped;
  logic half;
  // shadow of even control, the governing half when paired
  always_comb begin
    next_on   = on_q;
    next_pair = pair_q;
    if (wr_en && addr == tbt_pkg::OFF_EVEN_CTRL) begin
      next_on   = wdata[tbt_pkg::BIT_ON];
      next_pair = wdata[tbt_pkg::BIT_PAIR];
    end
  end
  always_ff @(posedge clk) begin
    on_q   <= rst_n ? next_on : 1'b0;
    pair_q <= rst_n ? next_pair : 1'b0;
  end
  assign half = addr inside {8'h04, 8'h08, 8'h14, 8'h18};
  assign mapped = half || addr == 8'h00 || addr == 8'h10;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence rd_ctrl_s;
    rd_en && (addr == 8'h00 || addr == 8'h10);
  endsequence
  sequence rd_odd_s;
    rd_en && addr == tbt_pkg::OFF_ODD_CTRL;
  endsequence
  sequence paired_s;
    pair_q ##1 pair_q;
  endsequence
  rd_quiet_a: assert property (!rd_en |=> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  rd_unmapped_a: assert property (rd_en && !mapped |=> rdata == 0)
    else $error("unmapped read not zero");
  ctrl_reserved_a: assert property (
    rd_ctrl_s |=> (rdata & 32'hffff_5f05) == 0)
    else $error("reserved control bits not zero");
  gate_reads_zero_a: assert property (
    rd_ctrl_s |=> !(rdata[7] && rdata[1]))
    else $error("gate bit seen with external source");
  odd_pair_absent_a: assert property (rd_odd_s |=> !rdata[3])
    else $error("odd pairing bit reads one");
  paired_odd_quiet_a: assert property (paired_s |-> !match_odd)
    else $error("odd match while paired");
  off_stays_quiet_a: assert property (
    (!on_q)[*2] |-> !match_even && !gate_done_even)
    else $error("even timer active while off");
  half_upper_zero_a: assert property (rd_en && half |=> rdata[31:16] == 0)
    else $error("count or period upper half not zero");
endmodule

bind tbt_timer_pair tbt_timer_pair_checker tbt_timer_pair_checker_i (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .match_even(match_even),
  .match_odd(match_odd), .gate_done_even(gate_done_even));

// ### type_b_timer_control_bench.sv
// self-checking bench for the type b timer pair
`timescale 1ns/10ps
module type_b_timer_control_bench;
  logic        clk = 0;
  logic        rst_n = 0;
  logic [7:0]  addr = 0;
  logic [31:0] wdata = 0;
  logic        wr_en = 0;
  logic        rd_en = 0;
  logic [31:0] rdata;
  logic        idle_mode = 0;
  logic        pin_e = 0;
  logic        pin_o = 0;
  logic        match_even, match_odd, gate_done_even, gate_done_odd;
  logic [31:0] q[$];
  logic        rd_seen = 0;
  logic [31:0] seed = 55;
  logic [31:0] r;
  int          fails = 0;
  int          check_count = 0;
  int          n;
  int          dv[8] = '{1, 2, 4, 8, 16, 32, 64, 256};

  tbt_timer_pair tbt_timer_pair_i (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .idle_mode(idle_mode),
    .ext_clk_even(pin_e), .ext_clk_odd(pin_o), .match_even(match_even),
    .match_odd(match_odd), .gate_done_even(gate_done_even),
    .gate_done_odd(gate_done_odd));

  always #20 clk = ~clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic report_and_stop();
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // every write leaves the following cycle idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1;
    @(posedge clk);
    wr_en <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1;
    q.push_back(e);
    @(posedge clk);
    rd_en <= 0;
  endtask

  // counter cleared before enabling so each interval starts alike
  task automatic start(input logic [15:0] per, input logic [31:0] c);
    wr(8'h00, 0);
    wr(8'h04, 0);
    wr(8'h08, {16'h0, per});
    wr(8'h00, c);
  endtask

  task automatic wait_pulse(input int s, lim, input logic e, output int k);
    logic hit;
    hit = 0;
    k = 0;
    while (k < lim && !hit) begin
      @(negedge clk);
      k++;
      hit = s == 0 ? match_even : s == 1 ? match_odd
          : s == 2 ? gate_done_even : gate_done_odd;
    end
    chk("pulse", {31'h0, hit}, {31'h0, e});
  endtask

  task automatic toggle(input int k);
    repeat (k) begin
      repeat (3) @(posedge clk);
      pin_e <= ~pin_e;
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen)
      chk("rdata", rdata, q.pop_front());
    rd_seen <= rd_en;
  end

  initial begin
    #(40 * 20000);
    fails++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    rd(8'h00, 0);
    rd(8'h04, 0);
    rd(8'h08, 32'h0000_ffff);
    rd(8'h10, 0);
    rd(8'h18, 32'h0000_ffff);
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, 0);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h0000_a07a);
    wr(8'h00, 32'hffff_fffd);
    rd(8'h00, 32'h0000_a0f8);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0000_a072);
    wr(8'h10, 0);
    repeat (3) begin
      r = xs();
      wr(8'h18, r);
      rd(8'h18, {16'h0, r[15:0]});
    end
    for (int i = 0; i < 8; i++) begin
      start(1, 32'h0000_8000 | (i << 4));
      wait_pulse(0, 600, 1, n);
      wait_pulse(0, 600, 1, n);
      chk("interval", n, 2 * dv[i]);
    end
    start(1, 0);
    wait_pulse(0, 30, 0, n);
    @(posedge clk);
    idle_mode <= 1;
    start(1, 32'h0000_a000);
    wait_pulse(0, 40, 0, n);
    wr(8'h00, 32'h0000_8000);
    wait_pulse(0, 10, 1, n);
    wr(8'h14, 0);
    wr(8'h18, 0);
    wr(8'h10, 32'h0000_0070);
    // odd idle stop left clear while paired
    start(1, 32'h0000_8008);
    wait_pulse(0, 10, 1, n);
    wait_pulse(0, 10, 1, n);
    chk("pair interval", n, 2);
    wait_pulse(1, 40, 0, n);
    @(posedge clk);
    idle_mode <= 0;
    wr(8'h00, 0);
    wr(8'h10, 32'h0000_8000);
    wait_pulse(1, 10, 1, n);
    wr(8'h10, 0);
    pin_e <= 1;
    start(1, 32'h0000_8082);
    wait_pulse(0, 40, 0, n);
    fork
      toggle(10);
      wait_pulse(0, 60, 1, n);
    join
    start(1, 32'h0000_8080);
    wait_pulse(0, 20, 1, n);
    @(posedge clk);
    pin_e <= 0;
    wait_pulse(2, 10, 1, n);
    repeat (3) @(negedge clk);
    wait_pulse(0, 30, 0, n);
    wr(8'h10, 32'h0000_8080);
    pin_o <= 1;
    wait_pulse(1, 20, 1, n);
    @(posedge clk);
    pin_o <= 0;
    wait_pulse(3, 10, 1, n);
    report_and_stop();
  end
endmodule
